// ===== core/charge_seq_cfg.svh
// Offsets, field positions, reset values and timing counts of the charge-mode sequencer.
`ifndef CHARGE_SEQ_CFG_SVH
`define CHARGE_SEQ_CFG_SVH

// Register offsets, byte-wide register port.
`define REG_CHARGE_EN      8'h06
`define REG_SEQ_CTRL       8'h0a
`define REG_AUTO_CFG       8'h25
`define REG_OFF_INTERVAL   8'h30
`define REG_POWER_STATUS   8'h31
`define REG_MODE_BASE      8'h40

// Field positions.
`define AUTO_N_BIT         1
`define HI_CUR_BIT         4
`define FULL_AUTO_BIT      0
`define VENDOR_N_BIT       1

// Reset values.
`define CHARGE_EN_RST      4'h0
`define HI_CUR_RST         1'b1
`define FULL_AUTO_RST      1'b0
`define VENDOR_N_RST       1'b1
`define OFF_INTERVAL_RST   8'h0a

// Timing: one off-interval tick is one millisecond at the reference clock rate.
`define CLK_MHZ            10
`define TICK_US            1000
`define TICK_CNT_W         14

`endif

// ===== core/charge_seq_pkg.sv
// Types shared by the charge-mode sequencer and its users.
`default_nettype none
package charge_seq_pkg;

    typedef enum logic [7:0] {
        mode_off      = 8'h01,
        mode_cdp      = 8'h02,
        mode_dcp      = 8'h04,
        mode_div_high = 8'h08,
        mode_div_mid  = 8'h10,
        mode_div_low  = 8'h20,
        mode_vendor   = 8'h40,
        mode_gap      = 8'h80
    } mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] port_charge_enable_pins;
        logic       auto_sequence_pin_n;
        logic       full_auto_sequence_pin;
        logic       per_port_power_select_n;
        logic       ganged;
        logic       host_bus_select_n;
        logic       power_output_polarity_pin;
        logic       eeprom_present;
    } strap_t;

endpackage
`default_nettype wire

// ===== core/charge_seq.sv
// Per-port charging-mode sequencer for a four-port hub.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "charge_seq_cfg.svh"

module charge_seq
    import charge_seq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_US * `CLK_MHZ,
    parameter logic        PIN_VENDOR_N = 1'b1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire reg_req_t    reg_req,
    output logic [7:0]       rd_data,
    // Configuration pins, latched once after reset release
    input  wire strap_t      straps,
    // Upstream and hub state
    input  wire logic        upstream_vbus_valid,
    input  wire logic        hub_configured,
    input  wire logic [3:0]  host_port_power,
    // Downstream data-line detectors
    input  wire logic [3:0]  dp_pullup,
    input  wire logic [3:0]  data_line_voltage_detect,
    // Port controls
    output logic [3:0]       port_power_en,
    output mode_t [3:0]      port_mode,
    output logic             per_port_managed
);

    typedef struct packed {
        logic [3:0]                 charge_en;
        logic                       auto_n;
        logic                       hi_cur;
        logic                       full_auto;
        logic                       vendor_n;
        logic [7:0]                 off_ivl;
        strap_t                     pins;
        logic                       strapped;
        logic [`TICK_CNT_W-1:0]     tick_cnt;
        logic                       tick;
        mode_t [3:0]                mode;
        mode_t [3:0]                after;
        logic [3:0][7:0]            gap_cnt;
        logic [3:0]                 pwr;
        logic [3:0]                 pwr_pin;
        logic                       managed;
        logic [7:0]                 rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [3:0] eff_en;
    logic       eff_auto;
    logic       eff_full;
    logic       eff_hi;
    logic       eff_vendor;
    logic       pin_cfg;

    function automatic mode_t first_div(input logic hi);
        return hi ? mode_div_high : mode_div_mid;
    endfunction

    function automatic mode_t next_div(input mode_t cur, input logic full, input logic ven);
        if (full && cur == mode_div_high) begin
            return mode_div_mid;
        end
        if (full && cur == mode_div_mid) begin
            return mode_div_low;
        end
        return ven ? mode_vendor : mode_dcp;
    endfunction

    // Pin-configured builds without EEPROM ignore the register settings, except the off interval.
    always_comb begin
        pin_cfg    = s_q.pins.host_bus_select_n && !s_q.pins.eeprom_present;
        eff_en     = pin_cfg ? s_q.pins.port_charge_enable_pins : s_q.charge_en;
        eff_auto   = pin_cfg ? 1'b1 : !s_q.auto_n;
        eff_full   = pin_cfg ? 1'b1 : s_q.full_auto;
        eff_hi     = pin_cfg ? 1'b1 : s_q.hi_cur;
        eff_vendor = pin_cfg ? !PIN_VENDOR_N : !s_q.vendor_n;
    end

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == `TICK_CNT_W'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + `TICK_CNT_W'(1);
        end

        // The pins are caught on the first edge after reset release, so no flop
        // ever loads a port value asynchronously.
        if (!s_q.strapped) begin
            s_d.strapped = 1'b1;
            s_d.pins = straps;
            s_d.charge_en = straps.port_charge_enable_pins;
            s_d.auto_n = straps.auto_sequence_pin_n;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                `REG_CHARGE_EN: s_d.charge_en = reg_req.wdata[3:0];
                `REG_SEQ_CTRL: begin
                    s_d.auto_n = reg_req.wdata[`AUTO_N_BIT];
                    s_d.hi_cur = reg_req.wdata[`HI_CUR_BIT];
                end
                `REG_AUTO_CFG: begin
                    s_d.full_auto = reg_req.wdata[`FULL_AUTO_BIT];
                    s_d.vendor_n = reg_req.wdata[`VENDOR_N_BIT];
                end
                `REG_OFF_INTERVAL: s_d.off_ivl = reg_req.wdata;
                default: ;
            endcase
        end

        for (int i = 0; i < 4; i++) begin
            if (!eff_en[i]) begin
                s_d.mode[i] = mode_off;
                s_d.pwr[i] = upstream_vbus_valid &&
                             (s_q.pins.ganged && !s_q.managed ? |host_port_power
                                                              : host_port_power[i]);
            end else if (upstream_vbus_valid) begin
                s_d.mode[i] = (hub_configured && host_port_power[i]) ? mode_cdp
                                                                     : mode_off;
                s_d.pwr[i] = host_port_power[i];
            end else if (!eff_auto) begin
                s_d.mode[i] = mode_dcp;
                s_d.pwr[i] = 1'b1;
            end else begin
                unique case (s_q.mode[i])
                    mode_gap: begin
                        // Power stays off until the interval has run out.
                        if (s_q.gap_cnt[i] == 8'h00) begin
                            s_d.mode[i] = s_q.after[i];
                        end else if (s_q.tick) begin
                            s_d.gap_cnt[i] = s_q.gap_cnt[i] - 8'h01;
                        end
                    end
                    mode_div_high, mode_div_mid, mode_div_low: begin
                        if (dp_pullup[i]) begin
                            s_d.mode[i] = mode_gap;
                            s_d.after[i] = next_div(s_q.mode[i], eff_full, eff_vendor);
                            s_d.gap_cnt[i] = s_q.off_ivl;
                        end
                    end
                    mode_vendor: begin
                        if (dp_pullup[i]) begin
                            s_d.mode[i] = mode_gap;
                            s_d.after[i] = mode_dcp;
                            s_d.gap_cnt[i] = s_q.off_ivl;
                        end
                    end
                    mode_dcp: begin
                        if (dp_pullup[i] || data_line_voltage_detect[i]) begin
                            s_d.mode[i] = mode_gap;
                            s_d.after[i] = first_div(eff_hi);
                            s_d.gap_cnt[i] = s_q.off_ivl;
                        end
                    end
                    default: begin
                        s_d.mode[i] = first_div(eff_hi);
                    end
                endcase
                s_d.pwr[i] = (s_d.mode[i] != mode_gap);
            end
        end

        s_d.managed = (|eff_en) || !s_q.pins.ganged;
        // Pin polarity: high selects an active-high enable.
        s_d.pwr_pin = s_q.pins.power_output_polarity_pin ? s_d.pwr : ~s_d.pwr;

        s_d.rdata = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `REG_CHARGE_EN: s_d.rdata = {4'h0, s_q.charge_en};
                `REG_SEQ_CTRL: begin
                    s_d.rdata[`AUTO_N_BIT] = s_q.auto_n;
                    s_d.rdata[`HI_CUR_BIT] = s_q.hi_cur;
                end
                `REG_AUTO_CFG: begin
                    s_d.rdata[`FULL_AUTO_BIT] = s_q.full_auto;
                    s_d.rdata[`VENDOR_N_BIT] = s_q.vendor_n;
                end
                `REG_OFF_INTERVAL: s_d.rdata = s_q.off_ivl;
                `REG_POWER_STATUS: s_d.rdata = {3'h0, s_q.managed, s_q.pwr};
                `REG_MODE_BASE: s_d.rdata = s_q.mode[0];
                `REG_MODE_BASE + 8'h01: s_d.rdata = s_q.mode[1];
                `REG_MODE_BASE + 8'h02: s_d.rdata = s_q.mode[2];
                `REG_MODE_BASE + 8'h03: s_d.rdata = s_q.mode[3];
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.charge_en <= `CHARGE_EN_RST;
            s_q.auto_n <= 1'b1;
            s_q.hi_cur <= `HI_CUR_RST;
            s_q.full_auto <= `FULL_AUTO_RST;
            s_q.vendor_n <= `VENDOR_N_RST;
            s_q.off_ivl <= `OFF_INTERVAL_RST;
            s_q.mode <= {4{mode_off}};
            s_q.after <= {4{mode_off}};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rdata;
    assign port_power_en = s_q.pwr_pin;
    assign port_mode = s_q.mode;
    assign per_port_managed = s_q.managed;

    // Checks on port 0; the other ports share the same logic.
    // A port is free to sequence only while it is enabled, unconnected and on auto.
    logic seq0;
    assign seq0 = s_q.strapped && !upstream_vbus_valid && eff_en[0] && eff_auto;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // A mode is registered, so what let it in are the inputs of one edge earlier.
    cdp_gate_a: assert property (
        s_q.mode[0] == mode_cdp
        |-> $past(upstream_vbus_valid && hub_configured && host_port_power[0]))
        else $error("CDP entered without its upstream conditions");

    cdp_offer_a: assert property (
        s_q.strapped && eff_en[0] && upstream_vbus_valid && hub_configured &&
        host_port_power[0]
        |=> s_q.mode[0] == mode_cdp)
        else $error("CDP not offered with its upstream conditions");

    off_port_a: assert property (
        s_q.strapped && !eff_en[0]
        |=> s_q.mode[0] == mode_off)
        else $error("Charging mode on a disabled port");

    charge_power_a: assert property (
        s_q.mode[0] inside {mode_dcp, mode_div_high, mode_div_mid, mode_div_low, mode_vendor}
        |-> s_q.pwr[0])
        else $error("Charging mode without port power");

    custom_gate_a: assert property (
        s_q.mode[0] inside {mode_div_high, mode_div_mid, mode_div_low, mode_vendor}
        |-> $past(!upstream_vbus_valid && eff_auto))
        else $error("Custom mode outside unconnected auto sequencing");

    no_auto_dcp_a: assert property (
        s_q.strapped && !upstream_vbus_valid && eff_en[0] && !eff_auto
        |=> s_q.mode[0] == mode_dcp)
        else $error("DCP not used with auto sequencing off");

    connect_stop_a: assert property (
        s_q.strapped && upstream_vbus_valid
        |=> s_q.mode[0] inside {mode_cdp, mode_off})
        else $error("Sequencing went on with the upstream port connected");

    hi_start_a: assert property (
        seq0 && s_q.mode[0] inside {mode_off, mode_cdp}
        |=> s_q.mode[0] == ($past(eff_hi) ? mode_div_high : mode_div_mid))
        else $error("Sequencing did not start at the selected divider level");

    // Detection handling while the port sequences.
    div_hold_a: assert property (
        seq0 && !dp_pullup[0] &&
        s_q.mode[0] inside {mode_div_high, mode_div_mid, mode_div_low}
        |=> s_q.mode[0] == $past(s_q.mode[0]))
        else $error("Divider level left without a pull-up");

    div_pullup_a: assert property (
        seq0 && dp_pullup[0] &&
        s_q.mode[0] inside {mode_div_high, mode_div_mid, mode_div_low}
        |=> s_q.mode[0] == mode_gap && !s_q.pwr[0] &&
            s_q.after[0] == next_div($past(s_q.mode[0]), $past(eff_full), $past(eff_vendor)))
        else $error("Divider pull-up not handled");

    full_step_a: assert property (
        seq0 && eff_full && dp_pullup[0] && s_q.mode[0] == mode_div_high
        |=> s_q.after[0] == mode_div_mid)
        else $error("Full-auto skipped the middle divider level");

    low_step_a: assert property (
        seq0 && eff_full && dp_pullup[0] && s_q.mode[0] == mode_div_mid
        |=> s_q.after[0] == mode_div_low)
        else $error("Full-auto skipped the lowest divider level");

    vendor_skip_a: assert property (
        seq0 && dp_pullup[0] && s_q.mode[0] == mode_div_low
        |=> s_q.after[0] == ($past(eff_vendor) ? mode_vendor : mode_dcp))
        else $error("Last divider level did not head to vendor mode or DCP");

    vendor_hold_a: assert property (
        seq0 && !dp_pullup[0] && s_q.mode[0] == mode_vendor
        |=> s_q.mode[0] == mode_vendor)
        else $error("Vendor mode left without a pull-up");

    vendor_pullup_a: assert property (
        seq0 && dp_pullup[0] && s_q.mode[0] == mode_vendor
        |=> s_q.mode[0] == mode_gap && s_q.after[0] == mode_dcp)
        else $error("Vendor pull-up did not head to DCP");

    dcp_hold_a: assert property (
        seq0 && s_q.mode[0] == mode_dcp &&
        !dp_pullup[0] && !data_line_voltage_detect[0]
        |=> s_q.mode[0] == mode_dcp)
        else $error("DCP left without a detect");

    dcp_return_a: assert property (
        seq0 && s_q.mode[0] == mode_dcp &&
        (dp_pullup[0] || data_line_voltage_detect[0])
        |=> s_q.mode[0] == mode_gap && s_q.after[0] == first_div($past(eff_hi)))
        else $error("DCP detect did not return to divider");

    // The off interval between two modes.
    gap_exit_a: assert property (
        seq0 && s_q.mode[0] == mode_gap && s_q.gap_cnt[0] == 8'h00
        |=> s_q.mode[0] == $past(s_q.after[0]) && s_q.pwr[0])
        else $error("Off interval did not end into the next mode");

    gap_hold_a: assert property (
        seq0 && s_q.mode[0] == mode_gap && s_q.gap_cnt[0] != 8'h00
        |=> s_q.mode[0] == mode_gap && !s_q.pwr[0])
        else $error("Off interval ended early");

    // Configuration capture and power management.
    strap_catch_a: assert property (
        $rose(s_q.strapped)
        |-> s_q.pins == $past(straps))
        else $error("Pins not latched at reset release");

    managed_a: assert property (
        s_q.strapped && |eff_en
        |=> per_port_managed)
        else $error("Charging without per-port power management");

    vendor_seen_c: cover property (s_q.mode[0] == mode_vendor);
    dcp_cycle_c: cover property (s_q.mode[0] == mode_dcp ##1 s_q.mode[0] == mode_gap);
    cdp_seen_c: cover property (s_q.mode[0] == mode_cdp);
    div_low_c: cover property (s_q.mode[0] == mode_div_low);
    gap_seen_c: cover property (s_q.mode[0] == mode_gap ##1 s_q.mode[0] != mode_gap);

endmodule // charge_seq
`default_nettype wire

// ===== sim/device_model.sv
// Portable devices on the four charging ports, seen through their data-line detectors.
`timescale 1ns/1ps
`default_nettype none
module device_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Port power as seen by the devices, and what the bench asks them to do
    input  wire logic [3:0] power_on,
    input  wire logic [3:0] want_pull,
    input  wire logic [3:0] want_vdat,
    // Detector levels back into the hub
    output logic [3:0]      dp_pullup,
    output logic [3:0]      vdat
);
    // An unpowered device cannot hold its pull-up, so a power drop clears both levels.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dp_pullup <= 4'h0;
            vdat      <= 4'h0;
        end else begin
            dp_pullup <= want_pull & power_on;
            vdat      <= want_vdat & power_on;
        end
    end
endmodule // device_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench of the charge-mode sequencer with a reference model of its sequence.
`timescale 1ns/1ps
`default_nettype none
`include "charge_seq_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    import charge_seq_pkg::*;
    logic        ref_clk, rst, vbus, cfg;
    logic [3:0]  hpp, want_p, want_v, pull, vdat, pwr;
    logic [7:0]  rd_data, d;
    reg_req_t    reg_req;
    strap_t      straps, reg_straps, pin_straps;
    mode_t [3:0] port_mode;
    logic        managed;
    mode_t       seq[$];
    int          fails, n_checks, w, ivl;
    localparam bit PIN_VENDOR_N_DEF = 1'b1;

    charge_seq #(.TICK_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
        .rd_data(rd_data), .straps(straps), .upstream_vbus_valid(vbus), .hub_configured(cfg),
        .host_port_power(hpp), .dp_pullup(pull), .data_line_voltage_detect(vdat),
        .port_power_en(pwr), .port_mode(port_mode), .per_port_managed(managed));
    device_model i_device (.ref_clk(ref_clk), .rst(rst), .power_on(pwr), .want_pull(want_p),
        .want_vdat(want_v), .dp_pullup(pull), .vdat(vdat));

    task automatic cyc(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        cyc();
        reg_req.wr <= 1'b0;
        cyc();
    endtask
    // Read data stand only in the cycle after the strobe, and read zero after that.
    task automatic rd(logic [7:0] a, output logic [7:0] v);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        cyc();
        reg_req.rd <= 1'b0;
        v = rd_data;
        cyc();
        `CHK(rd_data, 8'h00)
    endtask
    task automatic do_reset(strap_t s);
        straps <= s;
        rst <= 1'b1;
        cyc(10);
        `CHK(port_mode[0], mode_off)
        rst <= 1'b0;
        cyc();
    endtask
    // Expected mode order: the divider levels allowed, vendor mode if on, then DCP.
    function automatic void build(bit full, bit hi, bit ven);
        seq = {};
        if (hi) seq.push_back(mode_div_high);
        if (!hi || full) seq.push_back(mode_div_mid);
        if (full) seq.push_back(mode_div_low);
        if (ven) seq.push_back(mode_vendor);
        seq.push_back(mode_dcp);
    endfunction
    task automatic step(int p, mode_t cur, mode_t nxt, int iv);
        int n;
        `CHK(port_mode[p], cur)
        `CHK(pwr[p], 1'b1)
        if (cur == mode_dcp && $urandom % 2) want_v[p] <= 1'b1;
        else want_p[p] <= 1'b1;
        n = 0;
        while (port_mode[p] !== mode_gap && n < 10) begin cyc(); n++; end
        `CHK(port_mode[p], mode_gap)
        `CHK(pwr[p], 1'b0)
        want_p[p] <= 1'b0;
        want_v[p] <= 1'b0;
        n = 0;
        while (port_mode[p] === mode_gap && n < 100) begin cyc(); n++; end
        `CHK(n >= (iv == 0 ? 1 : iv * 4 - 3) && n <= iv * 4 + 6, 1'b1)
        `CHK(port_mode[p], nxt)
        `CHK(pwr[p], 1'b1)
    endtask
    task automatic settle(int p, mode_t m);
        w = 0;
        while (port_mode[p] !== m && w < 200) begin cyc(); w++; end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        print_verdict();
    end
    initial begin
        rst = 1'b1; vbus = 1'b1; cfg = 1'b0; hpp = 4'h1; want_p = 4'h0; want_v = 4'h0;
        reg_req = '0; fails = 0; n_checks = 0;
        reg_straps = '{port_charge_enable_pins: 4'b0011, auto_sequence_pin_n: 1'b0,
            full_auto_sequence_pin: 1'b0, per_port_power_select_n: 1'b0, ganged: 1'b1,
            host_bus_select_n: 1'b0, power_output_polarity_pin: 1'b1, eeprom_present: 1'b1};
        pin_straps = reg_straps;
        pin_straps.port_charge_enable_pins = 4'b0100;
        pin_straps.host_bus_select_n = 1'b1;
        pin_straps.eeprom_present = 1'b0;
        straps = reg_straps;
        void'($urandom(32'h5e97));
        do_reset(reg_straps);
        rd(`REG_CHARGE_EN, d); `CHK(d, 8'h03)
        rd(`REG_SEQ_CTRL, d); `CHK(d & 8'h12, 8'h10)
        rd(`REG_AUTO_CFG, d); `CHK(d & 8'h03, 8'h02)
        rd(`REG_OFF_INTERVAL, d); `CHK(d, `OFF_INTERVAL_RST)
        rd(8'h7f, d);
        `CHK(d, 8'h00)
        `CHK(port_mode[0], mode_off)
        cfg <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            ivl = $urandom % 3;
            wr(`REG_SEQ_CTRL, {3'b000, c[1], 4'b0000});
            wr(`REG_AUTO_CFG, {6'b000000, !c[2], c[0]});
            wr(`REG_OFF_INTERVAL, ivl[7:0]);
            `CHK(port_mode[0], mode_cdp)
            `CHK(pwr[0], 1'b1)
            `CHK(port_mode[1], mode_off)
            build(c[0], c[1], c[2]);
            vbus <= 1'b0;
            settle(0, seq[0]);
            cyc(20);
            `CHK(port_mode[0], seq[0])
            wr(`REG_POWER_STATUS, 8'hff);
            rd(`REG_POWER_STATUS, d); `CHK(d, 8'h13)
            `CHK(managed, 1'b1)
            rd(`REG_MODE_BASE, d);
            `CHK(d, seq[0])
            for (int k = 0; k <= seq.size(); k++)
                step(0, seq[k % seq.size()], seq[(k + 1) % seq.size()], ivl);
            vbus <= 1'b1;
            cyc(2);
        end
        wr(`REG_SEQ_CTRL, 8'h12);
        vbus <= 1'b0;
        cyc(3);
        `CHK(port_mode[0], mode_dcp)
        `CHK(pwr[0], 1'b1)
        do_reset(pin_straps);
        straps.port_charge_enable_pins <= 4'b0001;
        wr(`REG_CHARGE_EN, 8'h01);
        settle(2, mode_div_high);
        `CHK(port_mode[0], mode_off)
        build(1'b1, 1'b1, !PIN_VENDOR_N_DEF);
        for (int k = 0; k <= seq.size(); k++)
            step(2, seq[k % seq.size()], seq[(k + 1) % seq.size()], 10);
        // Active-low enables: charging ports read low, idle ports high.
        reg_straps.power_output_polarity_pin = 1'b0;
        do_reset(reg_straps);
        cyc(3);
        `CHK(pwr, 4'hc)
        `CHK(port_mode[0], mode_div_high)
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
